// *** verilog/xtrf_top.sv ***
// XT local register file: byte registers, mode/status and drive type.
`timescale 1ns/1ps
module xtrf_top (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 host_reset_pin,
  input  wire logic                 local_reset_pin,
  input  wire logic                 host_prog_reset,
  input  wire logic                 xt_select,
  input  wire logic [7:0]           mc_addr,
  input  wire logic                 mc_wr,
  input  wire logic                 mc_rd,
  input  wire logic [7:0]           mc_wdata,
  output logic      [7:0]           mc_rdata,
  input  wire logic                 host_select,
  input  wire logic                 host_byte_wr,
  input  wire logic                 host_byte_rd,
  input  wire logic [7:0]           host_wdata,
  output logic      [7:0]           host_rdata,
  input  wire logic                 buffer_active,
  input  wire logic                 master_slave_mode,
  input  wire logic                 slave_unit,
  output logic      [7:0]           host_status,
  output logic      [7:0]           host_drive_type,
  output logic      [7:0]           host_drive_oe,
  output xtrf_pkg::xtrf_phase_type  host_phase,
  output logic                      mc_locked
);
  import xtrf_pkg::*;

  typedef struct packed {
    logic           busy;
    logic           cmd_data;
    logic           dir_out;
    logic           reg_req;
    logic           buf_act;
    logic [2:0]     count;
    logic [2:0]     ptr;
    xtrf_phase_type phase;
    logic [7:0]     mc_rdata;
    logic [7:0]     host_rdata;
    logic [7:0]     drive_oe;
  } xtrf_state_type;

  xtrf_state_type q;
  xtrf_state_type next_q;
  logic [7:0]     drive_type;
  logic [7:0]     next_drive_type;
  logic [7:0]     mode_byte;
  logic           mc_hit_bytes;
  logic           mc_hit_mode;
  logic           mc_hit_drive;
  logic           host_move;
  logic           last_byte;
  logic           clear_mode;

  xtrf_bytes_if bytes_bus ();

  xtrf_byte_store #(
    .DEPTH (XTRF_BYTE_COUNT)
  ) u_store (
    .clk_sys (clk_sys),
    .bus     (bytes_bus.store)
  );

  // Address decode, gated by the XT/AT selection from outside
  assign mc_hit_bytes = xt_select && ((mc_addr[7:3] == XTRF_BYTES_BASE_A[7:3]) ||
                                      (mc_addr[7:3] == XTRF_BYTES_BASE_B[7:3])); // RULE22
  assign mc_hit_mode  = xt_select && (mc_addr == XTRF_MODE_ADDR);
  assign mc_hit_drive = xt_select && (mc_addr == XTRF_DRIVE_ADDR);

  // Host may move a byte only while a transfer is granted, in the granted direction
  assign host_move = q.reg_req && ((host_byte_rd && q.dir_out) ||
                                   (host_byte_wr && !q.dir_out)); // RULE20 RULE3
  assign last_byte = (q.ptr == q.count); // RULE23
  assign clear_mode = host_reset_pin || local_reset_pin || host_prog_reset;

  assign mode_byte = {q.busy, q.cmd_data, q.dir_out, q.buf_act, q.reg_req, q.count};

  // Byte store port steering; the pointer owns the address during a transfer
  always_comb begin
    bytes_bus.wr_en     = (mc_wr && mc_hit_bytes && !q.reg_req) ||
                          (host_move && host_byte_wr); // RULE2 RULE1
    bytes_bus.wr_addr   = q.reg_req ? q.ptr : mc_addr[2:0];
    bytes_bus.wr_data   = q.reg_req ? host_wdata : mc_wdata;
    bytes_bus.mc_addr   = mc_addr[2:0];
    bytes_bus.host_addr = q.ptr; // RULE7
  end

  // Next state of the mode/status machine and the read paths
  always_comb begin
    next_q = q;
    next_q.buf_act = buffer_active; // RULE12
    if (host_move) begin
      next_q.ptr = q.ptr + 3'h1; // RULE7
      if (last_byte) begin
        next_q.ptr     = XTRF_PTR_RESET;
        next_q.reg_req = 1'b0; // RULE9 RULE23
      end
      if (host_byte_rd && q.busy && q.cmd_data && q.dir_out) begin
        next_q.busy = 1'b0; // RULE14
      end
    end
    // Selection wins over a status-read clear in the same cycle
    if (host_select) begin
      next_q.busy = 1'b1; // RULE14
    end
    // Software write wins over hardware completion, so a new request is not lost
    if (mc_wr && mc_hit_mode) begin
      next_q.busy     = mc_wdata[XTRF_BIT_BUSY]; // RULE19
      next_q.cmd_data = mc_wdata[XTRF_BIT_CMD]; // RULE13
      next_q.dir_out  = mc_wdata[XTRF_BIT_DIR]; // RULE3
      next_q.reg_req  = mc_wdata[XTRF_BIT_REQ]; // RULE9
      next_q.count    = mc_wdata[XTRF_CNT_MSB:0]; // RULE6
      if (mc_wdata[XTRF_BIT_REQ]) begin
        next_q.ptr = XTRF_PTR_RESET; // RULE7
      end
    end
    if (clear_mode) begin
      {next_q.busy, next_q.cmd_data, next_q.dir_out, next_q.buf_act,
       next_q.reg_req, next_q.count} = XTRF_MODE_RESET; // RULE5
      next_q.ptr = XTRF_PTR_RESET;
    end
    // Phase follows the mode bits as they will stand
    case ({next_q.busy, next_q.cmd_data, next_q.dir_out})
      3'b100:  next_q.phase = XTRF_DATA_IN; // RULE15
      3'b101:  next_q.phase = XTRF_DATA_OUT;
      3'b110:  next_q.phase = XTRF_COMMAND;
      3'b111:  next_q.phase = XTRF_STATUS;
      default: next_q.phase = XTRF_IDLE;
    endcase
    // Microcontroller read; locked bytes and unmapped addresses read zero
    if (mc_rd) begin
      if (mc_hit_bytes) begin
        next_q.mc_rdata = q.reg_req ? XTRF_UNMAPPED : bytes_bus.mc_data; // RULE2
      end else if (mc_hit_mode) begin
        next_q.mc_rdata = mode_byte; // RULE8
      end else if (mc_hit_drive) begin
        next_q.mc_rdata = drive_type; // RULE16
      end else begin
        next_q.mc_rdata = XTRF_UNMAPPED;
      end
    end
    if (host_move && host_byte_rd) begin
      next_q.host_rdata = bytes_bus.host_data; // RULE1
    end
    if (master_slave_mode) begin
      next_q.drive_oe = slave_unit ? XTRF_OE_SLAVE : XTRF_OE_MASTER; // RULE18
    end else begin
      next_q.drive_oe = XTRF_OE_ALL; // RULE18
    end
  end

  // Control state; reset leaves it idle with nothing granted
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '{busy: 1'b0, cmd_data: 1'b0, dir_out: 1'b0, reg_req: 1'b0, buf_act: 1'b0,
             count: 3'h0, ptr: 3'h0, phase: XTRF_IDLE, mc_rdata: 8'h00,
             host_rdata: 8'h00, drive_oe: 8'h00};
    end else begin
      q <= next_q;
    end
  end

  // Drive type has no host write path and no reset at all
  always_comb begin
    next_drive_type = drive_type;
    if (mc_wr && mc_hit_drive) begin
      next_drive_type = mc_wdata; // RULE16
    end
  end

  always_ff @(posedge clk_sys) begin
    drive_type <= next_drive_type; // RULE17
  end

  assign mc_rdata        = q.mc_rdata;
  assign host_rdata      = q.host_rdata;
  assign host_status     = mode_byte;
  assign host_drive_type = drive_type;
  assign host_drive_oe   = q.drive_oe;
  assign host_phase      = q.phase;
  assign mc_locked       = q.reg_req;

  // Checks on the control logic
  chk_req_clears_done: assert property (@(posedge clk_sys) disable iff (rst) // RULE23
    (host_move && last_byte && !(mc_wr && mc_hit_mode) && !host_select) |=> !q.reg_req)
    else $error("request bit not cleared after last byte");

  chk_ptr_steps: assert property (@(posedge clk_sys) disable iff (rst) // RULE7
    (host_move && !last_byte && !clear_mode && !(mc_wr && mc_hit_mode))
      |=> q.ptr == $past(q.ptr) + 3'h1)
    else $error("pointer did not advance by one");

  chk_req_start_ptr: assert property (@(posedge clk_sys) disable iff (rst) // RULE9
    (mc_wr && mc_hit_mode && mc_wdata[XTRF_BIT_REQ] && !clear_mode)
      |=> q.reg_req && q.ptr == 3'h0)
    else $error("request did not start at register zero");

  chk_mode_cleared: assert property (@(posedge clk_sys) disable iff (rst) // RULE5
    clear_mode |=> mode_byte[7:5] == 3'h0 && !q.reg_req && q.count == 3'h0)
    else $error("mode register survived a reset source");

  chk_lock_blocks: assert property (@(posedge clk_sys) disable iff (rst) // RULE2
    (q.reg_req && mc_rd && mc_hit_bytes) |=> q.mc_rdata == XTRF_UNMAPPED)
    else $error("microcontroller read a locked byte register");

  chk_busy_select: assert property (@(posedge clk_sys) disable iff (rst) // RULE14
    (host_select && !clear_mode && !(mc_wr && mc_hit_mode)) |=> q.busy ##0 host_phase != XTRF_IDLE)
    else $error("busy not set on host selection");

  chk_status_clear: assert property (@(posedge clk_sys) disable iff (rst) // RULE14
    (host_move && host_byte_rd && q.phase == XTRF_STATUS && !host_select &&
     !(mc_wr && mc_hit_mode)) |=> !q.busy ##0 host_phase == XTRF_IDLE)
    else $error("busy not cleared by status read");

  chk_host_dir: assert property (@(posedge clk_sys) disable iff (rst) // RULE3
    (host_byte_wr && q.dir_out && !(mc_wr && mc_hit_bytes)) |-> !bytes_bus.wr_en)
    else $error("host wrote while direction is controller to host");

  chk_drive_mask: assert property (@(posedge clk_sys) disable iff (rst) // RULE18
    (master_slave_mode && !slave_unit) |=> host_drive_oe == XTRF_OE_MASTER)
    else $error("master drive mask wrong");

  chk_buf_flag: assert property (@(posedge clk_sys) disable iff (rst) // RULE12
    buffer_active |=> host_status[XTRF_BIT_BUF] || $past(clear_mode))
    else $error("buffer transfer flag not shown");

  // Count only moves on a mode write or a reset source, so a read returns it
  chk_count_hold: assert property (@(posedge clk_sys) disable iff (rst) // RULE8
    (!(mc_wr && mc_hit_mode) && !clear_mode) |=> $stable(q.count))
    else $error("transfer count changed without a mode write");

  chk_locked_write: assert property (@(posedge clk_sys) disable iff (rst) // RULE2
    (q.reg_req && mc_wr && mc_hit_bytes && !host_move) |-> !bytes_bus.wr_en)
    else $error("microcontroller wrote a locked byte register");

  chk_oe_all: assert property (@(posedge clk_sys) disable iff (rst) // RULE18
    !master_slave_mode |=> host_drive_oe == XTRF_OE_ALL)
    else $error("full drive mask missing outside master slave mode");

  chk_phase_idle: assert property (@(posedge clk_sys) disable iff (rst) // RULE15
    !q.busy |-> q.phase == XTRF_IDLE)
    else $error("phase not idle while busy is clear");

  cov_full_transfer: cover property (@(posedge clk_sys) disable iff (rst)
    host_move && last_byte && q.count == 3'h7);
  cov_status_read: cover property (@(posedge clk_sys) disable iff (rst)
    host_move && q.phase == XTRF_STATUS);
  cov_command_in: cover property (@(posedge clk_sys) disable iff (rst)
    host_move && q.phase == XTRF_COMMAND);
  cov_slave_mask: cover property (@(posedge clk_sys) disable iff (rst)
    host_drive_oe == XTRF_OE_SLAVE);

endmodule : xtrf_top

// *** verilog/xtrf_pkg.sv ***
// Constants and types shared by the XT local register file design.
// Summary of operation
// RULE1: Eight byte registers carry bytes between microcontroller and host, no buffer memory.
// RULE2: Microcontroller access to the byte registers is locked out during a host transfer.
// RULE3: Microcontroller always reads and writes bytes; direction bit decides host read or write.
// RULE4: No reset touches the byte registers.
// RULE5: Host reset pin, local reset pin or programmed reset clear the mode/status register.
// RULE6: Transfer count field holds bytes minus one, one to eight bytes.
// RULE7: Host transfer pointer starts at register 0 and steps one per byte.
// RULE8: Reading the count field returns the programmed count.
// RULE9: Writing 1 to the request bit starts a host transfer; it clears when done.
// RULE10: Microcontroller leaves byte registers alone while the request bit is set.
// RULE11: Microcontroller sets the request bit only while buffer transfer active reads 0.
// RULE12: Buffer transfer active bit reads 1 while host buffer transfers run.
// RULE13: Command-or-data bit tells the host command/status versus data.
// RULE14: Busy sets on host selection, clears when host reads the status byte.
// RULE15: Phase decodes from busy, command-or-data and direction per the phase table.
// RULE16: Drive type register is read/write for microcontroller, read-only for host.
// RULE17: No reset alters the drive type register.
// RULE18: Master drives drive type bits 3-0, slave bits 7-4, otherwise all eight.
// RULE19: Microcontroller can force the interface state by writing mode/status.
// RULE20: Host reaches the byte registers only as mode/status settings grant.
// RULE21: Microcontroller selects this file by setting the XT/AT selection bit to 1.
// RULE22: Eight byte registers at two aliased windows plus mode and drive type registers.
// RULE23: Transfer ends and request clears after count plus one bytes moved.
package xtrf_pkg;

  localparam int          XTRF_BYTE_COUNT   = 8;
  localparam logic [7:0]  XTRF_BYTES_BASE_A = 8'h40;
  localparam logic [7:0]  XTRF_BYTES_BASE_B = 8'h60;
  localparam logic [7:0]  XTRF_MODE_ADDR    = 8'h55;
  localparam logic [7:0]  XTRF_DRIVE_ADDR   = 8'h56;

  // Mode/status bit positions
  localparam int          XTRF_BIT_REQ      = 3;
  localparam int          XTRF_BIT_BUF      = 4;
  localparam int          XTRF_BIT_DIR      = 5;
  localparam int          XTRF_BIT_CMD      = 6;
  localparam int          XTRF_BIT_BUSY     = 7;
  localparam int          XTRF_CNT_MSB      = 2;

  localparam logic [7:0]  XTRF_MODE_RESET   = 8'h00;
  localparam logic [2:0]  XTRF_PTR_RESET    = 3'h0;
  localparam logic [7:0]  XTRF_OE_MASTER    = 8'h0F;
  localparam logic [7:0]  XTRF_OE_SLAVE     = 8'hF0;
  localparam logic [7:0]  XTRF_OE_ALL       = 8'hFF;
  localparam logic [7:0]  XTRF_UNMAPPED     = 8'h00;

  typedef enum logic [2:0] {
    XTRF_IDLE,
    XTRF_DATA_IN,
    XTRF_DATA_OUT,
    XTRF_COMMAND,
    XTRF_STATUS
  } xtrf_phase_type;

endpackage : xtrf_pkg

// *** verilog/xtrf_bytes_if.sv ***
// Carrier between the register file control and its byte store.
`timescale 1ns/1ps
interface xtrf_bytes_if;
  logic       wr_en;
  logic [2:0] wr_addr;
  logic [7:0] wr_data;
  logic [2:0] mc_addr;
  logic [2:0] host_addr;
  logic [7:0] mc_data;
  logic [7:0] host_data;

  modport ctl (output wr_en, output wr_addr, output wr_data, output mc_addr,
               output host_addr, input mc_data, input host_data);
  modport store (input wr_en, input wr_addr, input wr_data, input mc_addr,
                 input host_addr, output mc_data, output host_data);
endinterface : xtrf_bytes_if

// *** verilog/xtrf_byte_store.sv ***
// Eight command/general byte registers, one write port and two read ports.
`timescale 1ns/1ps
module xtrf_byte_store #(
  parameter int DEPTH = 8
) (
  input  wire logic   clk_sys,
  xtrf_bytes_if.store bus
);
  import xtrf_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
  } xtrf_store_type;

  xtrf_store_type q;
  xtrf_store_type next_q;

  // Write port shared by microcontroller and host; the lockout keeps them apart
  always_comb begin
    next_q = q;
    if (bus.wr_en) begin
      next_q.mem[bus.wr_addr] = bus.wr_data; // RULE1
    end
  end

  // No reset on purpose: contents survive every reset source
  always_ff @(posedge clk_sys) begin
    q <= next_q; // RULE4
  end

  assign bus.mc_data   = q.mem[bus.mc_addr];
  assign bus.host_data = q.mem[bus.host_addr];

endmodule : xtrf_byte_store

// *** test/xtrf_host_model.sv ***
// Host bus partner: selects the controller and strobes single bytes.
`timescale 1ns/1ps
module xtrf_host_model (
  input  wire logic       clk_sys,
  output logic            host_select,
  output logic            host_byte_rd,
  output logic            host_byte_wr,
  output logic [7:0]      host_wdata
);
  // Idle bus at time zero
  initial begin
    host_select = 1'b0;
    host_byte_rd = 1'b0;
    host_byte_wr = 1'b0;
    host_wdata = 8'h00;
  end

  // One-cycle selection pulse, raised and dropped on falling edges
  task automatic select();
    @(negedge clk_sys);
    host_select <= 1'b1;
    @(negedge clk_sys);
    host_select <= 1'b0;
  endtask : select

  // One byte strobe; the caller picks read or write with wr, whatever the bus phase
  task automatic strobe(input logic wr, input logic [7:0] d);
    @(negedge clk_sys);
    host_byte_wr <= wr;
    host_byte_rd <= !wr;
    host_wdata <= d;
    @(negedge clk_sys);
    host_byte_wr <= 1'b0;
    host_byte_rd <= 1'b0;
    host_wdata <= ~d; // Released data must not look stale
  endtask : strobe
endmodule : xtrf_host_model

// *** test/xt_local_register_file_tb_top.sv ***
// Self-checking bench for the XT local register file.
`timescale 1ns/1ps
module xt_local_register_file_tb_top;
  import xtrf_pkg::*;
  logic clk_sys, rst, host_reset_pin, local_reset_pin, host_prog_reset, xt_select;
  logic [7:0] mc_addr, mc_wdata, mc_rdata, host_rdata, host_status, host_drive_type;
  logic [7:0] host_drive_oe, host_wdata, r, d;
  logic mc_wr, mc_rd, host_select, host_byte_wr, host_byte_rd, buffer_active;
  logic master_slave_mode, slave_unit, mc_locked;
  xtrf_phase_type host_phase;
  logic [31:0] seed = 32'h0000_7DD0;
  logic [7:0] exp_b [8];
  int err_total = 0;
  int check_count = 0;

  xtrf_top u_dut (.clk_sys(clk_sys), .rst(rst), .host_reset_pin(host_reset_pin),
    .local_reset_pin(local_reset_pin), .host_prog_reset(host_prog_reset),
    .xt_select(xt_select), .mc_addr(mc_addr), .mc_wr(mc_wr), .mc_rd(mc_rd),
    .mc_wdata(mc_wdata), .mc_rdata(mc_rdata), .host_select(host_select),
    .host_byte_wr(host_byte_wr), .host_byte_rd(host_byte_rd), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .buffer_active(buffer_active),
    .master_slave_mode(master_slave_mode), .slave_unit(slave_unit),
    .host_status(host_status), .host_drive_type(host_drive_type),
    .host_drive_oe(host_drive_oe), .host_phase(host_phase), .mc_locked(mc_locked));
  xtrf_host_model u_host (.clk_sys(clk_sys), .host_select(host_select),
    .host_byte_rd(host_byte_rd), .host_byte_wr(host_byte_wr), .host_wdata(host_wdata));

  // 100 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Xorshift keeps the random stream repeatable
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  // Expected bus phase from busy, command-or-data and direction
  function automatic xtrf_phase_type phase_of(input logic [2:0] b);
    if (!b[2]) return XTRF_IDLE;
    if (b[1]) return b[0] ? XTRF_STATUS : XTRF_COMMAND;
    return b[0] ? XTRF_DATA_OUT : XTRF_DATA_IN;
  endfunction : phase_of

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Microcontroller strobes last one cycle, launched on falling edges
  task automatic mc_w(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    mc_addr = a;
    mc_wdata = v;
    mc_wr = 1'b1;
    @(negedge clk_sys);
    mc_wr = 1'b0;
    mc_wdata = ~v;
  endtask : mc_w

  task automatic mc_r(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk_sys);
    mc_addr = a;
    mc_rd = 1'b1;
    @(negedge clk_sys);
    mc_rd = 1'b0;
    v = mc_rdata;
  endtask : mc_r

  // Bounded wait for the transfer request to drop
  task automatic wait_unlock();
    int k;
    k = 0;
    while (mc_locked !== 1'b0 && k < 20) begin
      @(negedge clk_sys);
      k++;
    end
    if (mc_locked !== 1'b0) begin
      err_total++;
      wrap_up();
    end
  endtask : wait_unlock

  // Main sequence
  initial begin
    {host_reset_pin, local_reset_pin, host_prog_reset, mc_wr, mc_rd} = 5'h00;
    {buffer_active, master_slave_mode, slave_unit} = 3'h0;
    {mc_addr, mc_wdata} = 16'h0000;
    xt_select = 1'b1;
    rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    chk(host_status, XTRF_MODE_RESET);
    d = rnd();
    mc_w(XTRF_DRIVE_ADDR, d);
    mc_r(XTRF_DRIVE_ADDR, r);
    chk(r, d);
    chk(host_drive_type, d);
    for (int m = 0; m < 3; m++) begin
      master_slave_mode = (m != 0);
      slave_unit = (m == 2);
      repeat (2) @(negedge clk_sys);
      chk(host_drive_oe, m == 0 ? XTRF_OE_ALL : m == 1 ? XTRF_OE_MASTER : XTRF_OE_SLAVE);
    end
    mc_r(8'h57, r);
    chk(r, XTRF_UNMAPPED);
    // Every count: fill through either window, host reads back starting in status phase
    for (int n = 0; n < 8; n++) begin
      for (int i = 0; i < 8; i++) begin
        exp_b[i] = rnd();
        mc_w((i[0] ? XTRF_BYTES_BASE_B : XTRF_BYTES_BASE_A) + 8'(i), exp_b[i]);
      end
      mc_w(XTRF_MODE_ADDR, 8'hE8 | 8'(n));
      @(negedge clk_sys);
      chk({7'h00, mc_locked}, 8'h01);
      chk(host_status, 8'hE8 | 8'(n));
      chk(8'(host_phase), 8'(XTRF_STATUS));
      mc_r(XTRF_BYTES_BASE_A + 8'(n), r);
      chk(r, 8'h00);
      mc_w(XTRF_BYTES_BASE_B + 8'(n), ~exp_b[n]);
      u_host.strobe(1'b1, rnd()); // Wrong direction, must be ignored
      for (int i = 0; i <= n; i++) begin
        u_host.strobe(1'b0, 8'h00);
        chk(host_rdata, exp_b[i]);
        chk({7'h00, mc_locked}, 8'(i != n));
      end
      wait_unlock();
      chk(host_status, 8'h60 | 8'(n));
    end
    // Host writes a command after selection
    mc_w(XTRF_MODE_ADDR, 8'h4F);
    u_host.select();
    @(negedge clk_sys);
    chk(host_status[7:0], 8'hCF);
    chk(8'(host_phase), 8'(XTRF_COMMAND));
    for (int i = 0; i < 8; i++) begin
      exp_b[i] = rnd();
      u_host.strobe(1'b1, exp_b[i]);
    end
    wait_unlock();
    // Phase table forced by microcontroller writes
    for (int k = 0; k < 8; k++) begin
      mc_w(XTRF_MODE_ADDR, {3'(k), 5'h00});
      @(negedge clk_sys);
      chk(8'(host_phase), 8'(phase_of(3'(k))));
    end
    buffer_active = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk({7'h00, host_status[XTRF_BIT_BUF]}, 8'h01);
    buffer_active = 1'b0;
    // Each reset source clears mode/status only
    for (int s = 0; s < 3; s++) begin
      mc_w(XTRF_MODE_ADDR, 8'hE5);
      {host_reset_pin, local_reset_pin, host_prog_reset} = 3'b100 >> s;
      @(negedge clk_sys);
      {host_reset_pin, local_reset_pin, host_prog_reset} = 3'b000;
      @(negedge clk_sys);
      chk(host_status, XTRF_MODE_RESET);
    end
    // System reset in mid-run: mode cleared, bytes and drive type kept
    mc_w(XTRF_MODE_ADDR, 8'hE5);
    rst = 1'b1;
    @(negedge clk_sys);
    rst = 1'b0;
    chk(host_status, XTRF_MODE_RESET);
    for (int i = 0; i < 8; i++) begin
      mc_r(XTRF_BYTES_BASE_B + 8'(i), r);
      chk(r, exp_b[i]);
    end
    chk(host_drive_type, d);
    wrap_up();
  end
endmodule : xt_local_register_file_tb_top
